// >>> core/emb_defines.svh
// Constants of the external memory bus port
`ifndef EMB_DEFINES_SVH
`define EMB_DEFINES_SVH

// ==========================================================
// Bus widths and shared line layout
`define EMB_ADDR_W        16
`define EMB_DATA_W        16
`define EMB_SHARED_LO     6
`define EMB_SHARED_W      10
`define EMB_PORT_E_W      2
`define EMB_PORT_A_W      8
`define EMB_CNT_W         8

// ==========================================================
// Timing
`define EMB_CLK_PERIOD_NS 4
`define EMB_STROBE_NS     20
`define EMB_STROBE_CYC    ((`EMB_STROBE_NS + `EMB_CLK_PERIOD_NS - 1) / `EMB_CLK_PERIOD_NS)
`define EMB_SYNC_MIN_CYC  3

// ==========================================================
// Request buffer
`define EMB_FIFO_DEPTH    4

`endif

// >>> core/emb_pkg.sv
// Types shared by the external memory bus port
`include "emb_defines.svh"

package emb_pkg;

   // ==========================================================
   // One bus request as it travels through the buffer
   typedef struct packed {
      logic                   wr;    // High for a write cycle
      logic                   prog;  // High for program space
      logic [`EMB_ADDR_W-1:0] addr;  // Word address
      logic [`EMB_DATA_W-1:0] data;  // Write data
   } emb_req_type;

   // ==========================================================
   // Bus cycle sequencer states
   typedef enum logic [1:0] {
      EMB_IDLE   = 2'b00,
      EMB_SETUP  = 2'b01,
      EMB_STROBE = 2'b10,
      EMB_HOLD   = 2'b11
   } emb_state_type;

endpackage

// >>> core/emb_fifo.sv
// Request buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module emb_fifo #(
   parameter int WIDTH = 34,
   parameter int DEPTH = 4
) (
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   // ==========================================================
   // Parameter check
   initial begin
      if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1)
         $error("emb_fifo: DEPTH must be a power of two >= 2");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];  // Storage words
   logic [PW-1:0]    wr_ptr_q;       // Next slot to fill
   logic [PW-1:0]    rd_ptr_q;       // Oldest slot
   logic [CW-1:0]    count_q;        // Words held
   logic [CW-1:0]    count_d;        // Next word count
   logic             in_ready_q;     // Room for one more
   logic             out_valid_q;    // At least one word held
   wire              push;           // Word accepted
   wire              pop;            // Word handed on

   // ==========================================================
   // Handshakes
   assign push          = in_valid_in && in_ready_q;
   assign pop           = out_valid_q && out_ready_in;
   assign in_ready_out  = in_ready_q;
   assign out_valid_out = out_valid_q;
   assign out_data_out  = mem_q[rd_ptr_q];
   assign count_d       = count_q + CW'(push) - CW'(pop);

   // Pointers, count and flags
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wr_ptr_q    <= '0;
         rd_ptr_q    <= '0;
         count_q     <= '0;
         in_ready_q  <= 1'b0;
         out_valid_q <= 1'b0;
      end else begin
         wr_ptr_q    <= wr_ptr_q + PW'(push);
         rd_ptr_q    <= rd_ptr_q + PW'(pop);
         count_q     <= count_d;
         in_ready_q  <= count_d != CW'(DEPTH);
         out_valid_q <= count_d != '0;
      end
   end

   // Storage write
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data_in;
      end
   end
endmodule // emb_fifo

`default_nettype wire

// >>> core/emb_port.sv
// External memory bus port: strobes, address, data and shared I/O lines
`timescale 1ns/1ps
`default_nettype none
`include "emb_defines.svh"

module emb_port
   import emb_pkg::*;
#(
   parameter int STROBE_CYC = `EMB_STROBE_CYC,
   parameter int FIFO_DEPTH = `EMB_FIFO_DEPTH
) (
   input  wire logic                       clk_in,
   input  wire logic                       rst_in,
   // Request stream
   input  wire logic                       req_valid_in,
   input  wire emb_req_type                req_in,
   output logic                            req_ready_out,
   // Read answer
   output logic                            rd_valid_out,
   output logic [`EMB_DATA_W-1:0]          rd_data_out,
   // Bus control pins
   output logic                            program_space_select_n_out,
   output logic                            data_space_select_n_out,
   output logic                            read_strobe_n_out,
   output logic                            write_strobe_n_out,
   output logic                            ctl_oe_n_out,
   // Address pins
   output logic [`EMB_ADDR_W-1:0]          ext_addr_out,
   output logic [`EMB_ADDR_W-1:0]          ext_addr_oe_n_out,
   input  wire logic [`EMB_ADDR_W-1:0]     ext_addr_in,
   // Data pins
   output logic [`EMB_DATA_W-1:0]          ext_data_out,
   output logic                            ext_data_oe_n_out,
   input  wire logic [`EMB_DATA_W-1:0]     ext_data_in,
   // Shared lines, port E part
   input  wire logic [`EMB_PORT_E_W-1:0]   port_e_alt_io_sel_in,
   input  wire logic [`EMB_PORT_E_W-1:0]   port_e_alt_io_dir_in,
   input  wire logic [`EMB_PORT_E_W-1:0]   port_e_alt_io_dout_in,
   output logic [`EMB_PORT_E_W-1:0]        port_e_alt_io_din_out,
   // Shared lines, port A part
   input  wire logic [`EMB_PORT_A_W-1:0]   port_a_alt_io_sel_in,
   input  wire logic [`EMB_PORT_A_W-1:0]   port_a_alt_io_dir_in,
   input  wire logic [`EMB_PORT_A_W-1:0]   port_a_alt_io_dout_in,
   output logic [`EMB_PORT_A_W-1:0]        port_a_alt_io_din_out
);
   localparam int SW = `EMB_SHARED_W;
   localparam int LO = `EMB_SHARED_LO;
   localparam int AW = `EMB_ADDR_W;
   localparam int DW = `EMB_DATA_W;
   localparam int RW = $bits(emb_req_type);

   // ==========================================================
   // Parameter check: read data passes a two-stage synchroniser,
   // so the strobe must stay low long enough for it to settle
   initial begin
      if (STROBE_CYC < `EMB_SYNC_MIN_CYC || STROBE_CYC >= (1 << `EMB_CNT_W))
         $error("emb_port: STROBE_CYC out of range");
   end

   // ==========================================================
   // Declarations
   emb_state_type          state_q, state_d;     // Sequencer state
   logic [`EMB_CNT_W-1:0]  cnt_q, cnt_d;         // Strobe width counter
   emb_req_type            cur_q, cur_d;         // Request on the bus
   emb_req_type            fifo_data;            // Oldest buffered request
   logic                   fifo_valid;           // Buffer holds a request
   logic                   fifo_pop;             // Sequencer takes it
   logic                   ps_n_q, ds_n_q;       // Space selects
   logic                   rd_n_q, wr_n_q;       // Strobes
   logic                   ctl_oe_n_q;           // Control pin enable
   logic                   data_oe_n_q;          // Data pin enable
   logic [DW-1:0]          data_out_q;           // Data pin value
   logic [AW-1:0]          addr_q;               // Address pin value
   logic [AW-1:0]          addr_oe_n_q;          // Address pin enables
   logic [DW-1:0]          rdata_q;              // Captured read word
   logic                   rvalid_q;             // Read answer pulse
   logic [SW-1:0]          sel_q;                // Shared line is I/O
   logic [DW-1:0]          din_s1_q, din_s2_q;   // Data pin synchroniser
   logic [SW-1:0]          pin_s1_q, pin_s2_q;   // Shared pin synchroniser
   wire  [SW-1:0]          sel_all;              // Joined select inputs
   wire  [SW-1:0]          dir_all;              // Joined direction inputs
   wire  [SW-1:0]          dout_all;             // Joined output values
   wire                    in_cycle;             // Bus cycle next cycle
   wire                    rd_end;               // Read strobe ends now

   // ==========================================================
   // Request buffer
   emb_fifo #(
      .WIDTH (RW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_in        (clk_in),
      .rst_in        (rst_in),
      .in_valid_in   (req_valid_in),
      .in_ready_out  (req_ready_out),
      .in_data_in    (req_in),
      .out_valid_out (fifo_valid),
      .out_ready_in  (fifo_pop),
      .out_data_out  (fifo_data)
   );

   // ==========================================================
   // Decoding
   assign sel_all  = {port_a_alt_io_sel_in, port_e_alt_io_sel_in};
   assign dir_all  = {port_a_alt_io_dir_in, port_e_alt_io_dir_in};
   assign dout_all = {port_a_alt_io_dout_in, port_e_alt_io_dout_in};
   assign fifo_pop = (state_q == EMB_IDLE) && fifo_valid;
   assign in_cycle = state_d != EMB_IDLE;
   assign rd_end   = (state_q == EMB_STROBE) && (cnt_q == '0) && !cur_q.wr;

   // ==========================================================
   // Sequencer: idle, setup, strobe low, hold, one request at a time
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      cur_d   = cur_q;
      unique case (state_q)
         EMB_IDLE: begin
            // Take the oldest request and present address first
            if (fifo_valid) begin
               cur_d   = fifo_data;
               state_d = EMB_SETUP;
            end
         end
         EMB_SETUP: begin
            // Address settled, open the strobe
            cnt_d   = `EMB_CNT_W'(STROBE_CYC - 1);
            state_d = EMB_STROBE;
         end
         EMB_STROBE: begin
            // Count the strobe width down
            if (cnt_q == '0) begin
               state_d = EMB_HOLD;
            end else begin
               cnt_d = cnt_q - `EMB_CNT_W'(1);
            end
         end
         EMB_HOLD: begin
            // Address held past the strobe rise
            state_d = EMB_IDLE;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_q <= EMB_IDLE;
         cnt_q   <= '0;
         cur_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         cur_q   <= cur_d;
      end
   end

   // ==========================================================
   // Bus control pins, registered from the next state
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ps_n_q      <= 1'b1;
         ds_n_q      <= 1'b1;
         rd_n_q      <= 1'b1;
         wr_n_q      <= 1'b1;
         ctl_oe_n_q  <= 1'b1;
         data_oe_n_q <= 1'b1;
         data_out_q  <= '0;
      end else begin
         ps_n_q      <= !(in_cycle && cur_d.prog);
         ds_n_q      <= !(in_cycle && !cur_d.prog);
         wr_n_q      <= !(state_d == EMB_STROBE && cur_d.wr);
         rd_n_q      <= !(state_d == EMB_STROBE && !cur_d.wr);
         ctl_oe_n_q  <= 1'b0;
         data_oe_n_q <= !(in_cycle && cur_d.wr);
         data_out_q  <= cur_d.data;
      end
   end

   // ==========================================================
   // Address pins: bus function unless a shared line is selected as I/O
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sel_q       <= '0;
         addr_q      <= '0;
         addr_oe_n_q <= '1;
      end else begin
         sel_q                <= sel_all;
         addr_q[LO-1:0]       <= cur_d.addr[LO-1:0];
         addr_oe_n_q[LO-1:0]  <= '0;
         for (int i = 0; i < SW; i++) begin
            // Each shared line picks its own function and direction
            if (sel_q[i]) begin
               addr_q[LO+i]      <= dout_all[i];
               addr_oe_n_q[LO+i] <= !dir_all[i];
            end else begin
               addr_q[LO+i]      <= cur_d.addr[LO+i];
               addr_oe_n_q[LO+i] <= 1'b0;
            end
         end
      end
   end

   // ==========================================================
   // Pin synchronisers
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         din_s1_q <= '0;
         din_s2_q <= '0;
         pin_s1_q <= '0;
         pin_s2_q <= '0;
      end else begin
         din_s1_q <= ext_data_in;
         din_s2_q <= din_s1_q;
         pin_s1_q <= ext_addr_in[AW-1:LO];
         pin_s2_q <= pin_s1_q;
      end
   end

   // ==========================================================
   // Read capture on the edge where the read strobe rises
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rdata_q  <= '0;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= rd_end;
         if (rd_end) begin
            rdata_q <= din_s2_q;
         end
      end
   end

   // ==========================================================
   // Outputs
   assign program_space_select_n_out = ps_n_q;
   assign data_space_select_n_out    = ds_n_q;
   assign read_strobe_n_out          = rd_n_q;
   assign write_strobe_n_out         = wr_n_q;
   assign ctl_oe_n_out               = ctl_oe_n_q;
   assign ext_addr_out               = addr_q;
   assign ext_addr_oe_n_out          = addr_oe_n_q;
   assign ext_data_out               = data_out_q;
   assign ext_data_oe_n_out          = data_oe_n_q;
   assign rd_valid_out               = rvalid_q;
   assign rd_data_out                = rdata_q;
   assign port_e_alt_io_din_out      = pin_s2_q[`EMB_PORT_E_W-1:0];
   assign port_a_alt_io_din_out      = pin_s2_q[SW-1:`EMB_PORT_E_W];

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   // A read strobe that has just risen
   sequence s_rd_rise;
      !$past(rd_n_q) ##0 rd_n_q;
   endsequence

   property p_ps_sel;
      (!rd_n_q || !wr_n_q) |-> (ps_n_q == !cur_q.prog);
   endproperty
   a_ps_sel: assert property (p_ps_sel)
      else $error("program select wrong during strobe");

   property p_ds_sel;
      (!rd_n_q || !wr_n_q) |-> (ds_n_q == cur_q.prog) && (ps_n_q != ds_n_q);
   endproperty
   a_ds_sel: assert property (p_ds_sel)
      else $error("data select wrong during strobe");

   property p_wr_drive;
      !wr_n_q |-> !ext_data_oe_n_out && (ext_data_out == cur_q.data);
   endproperty
   a_wr_drive: assert property (p_wr_drive)
      else $error("write data not driven under write strobe");

   property p_qual;
      (!rd_n_q || !wr_n_q) |->
         (ext_addr_oe_n_out[LO-1:0] == '0) && !ctl_oe_n_q;
   endproperty
   a_qual: assert property (p_qual)
      else $error("address not driven under strobe");

   property p_rd_release;
      !rd_n_q |-> ext_data_oe_n_out;
   endproperty
   a_rd_release: assert property (p_rd_release)
      else $error("data lines driven during read");

   property p_rd_capture;
      s_rd_rise |-> rvalid_q && (rdata_q == $past(din_s2_q));
   endproperty
   a_rd_capture: assert property (p_rd_capture)
      else $error("read data not captured at strobe rise");

   property p_idle_float;
      (state_q == EMB_IDLE) |-> ext_data_oe_n_out && rd_n_q && wr_n_q;
   endproperty
   a_idle_float: assert property (p_idle_float)
      else $error("data lines driven while idle");

   property p_low_addr;
      (!rd_n_q || !wr_n_q) |-> ext_addr_out[LO-1:0] == cur_q.addr[LO-1:0];
   endproperty
   a_low_addr: assert property (p_low_addr)
      else $error("low address lines wrong");

   property p_reset_func;
      $past(rst_in) |-> (sel_q == '0) && (ext_addr_oe_n_out == '1);
   endproperty
   a_reset_func: assert property (p_reset_func)
      else $error("shared lines not in address function after reset");

   property p_io_dir;
      sel_q[0] |=> ext_addr_oe_n_out[LO] == !$past(dir_all[0]);
   endproperty
   a_io_dir: assert property (p_io_dir)
      else $error("shared line direction not followed");

   property p_excl;
      !(!rd_n_q && !wr_n_q);
   endproperty
   a_excl: assert property (p_excl)
      else $error("both strobes low");

   property p_stable;
      (!$past(rd_n_q) || !$past(wr_n_q)) && (!rd_n_q || !wr_n_q) |->
         $stable(ext_addr_out[LO-1:0]) && $stable(ps_n_q) && $stable(ds_n_q);
   endproperty
   a_stable: assert property (p_stable)
      else $error("address moved under strobe");

endmodule // emb_port

`default_nettype wire

// >>> tb/emb_mem_model.sv
// Static memory model on the far side of the external bus
`timescale 1ns/1ps
`default_nettype none

module emb_mem_model (
   input  wire logic        clk_in,
   input  wire logic        prog_sel_n_in,
   input  wire logic        data_sel_n_in,
   input  wire logic        read_n_in,
   input  wire logic        write_n_in,
   input  wire logic [15:0] addr_in,
   input  wire logic [15:0] data_in,
   input  wire logic        slow_in,
   output logic      [15:0] data_out
);
   // ==========================================================
   // Storage, both spaces keyed by {space, word address}
   logic [15:0] mem_q [int];   // Words written so far
   int          rd_cnt;        // Cycles the read strobe has been seen low
   logic [16:0] key;           // Space and address of the current cycle

   assign key = {~prog_sel_n_in, addr_in};

   // Word at a place, with a fixed pattern where nothing was written
   function automatic logic [15:0] lookup(input logic [16:0] k);
      if (mem_q.exists(int'(k)))
         return mem_q[int'(k)];
      return k[15:0] ^ (k[16] ? 16'h5555 : 16'haaaa);
   endfunction

   initial begin
      data_out = 16'h0000;
      rd_cnt   = 0;
   end

   // Latch the write data as the write strobe returns high
   always @(posedge write_n_in) begin
      if (!(prog_sel_n_in && data_sel_n_in)) begin
         mem_q[int'(key)] = data_in;
      end
   end

   // Drive read data while the read strobe is low; a slow part lags a cycle
   // Released lines toggle each cycle so no stale word can pass as data
   always @(posedge clk_in) begin
      if (!read_n_in && !(slow_in && rd_cnt == 0)) begin
         data_out <= lookup(key);
      end else begin
         data_out <= ~data_out;
      end
      rd_cnt <= read_n_in ? 0 : rd_cnt + 1;
   end
endmodule // emb_mem_model

`default_nettype wire

// >>> tb/tb_external_memory_bus_port.sv
// Self-checking bench for the external memory bus port
`timescale 1ns/1ps
`default_nettype none
`include "emb_defines.svh"

module tb_external_memory_bus_port
   import emb_pkg::*;
;
   // ==========================================================
   // Stimulus, pins and bench model state
   logic        clk_in, rst_in, req_valid_in, req_ready_out, rd_valid_out;
   emb_req_type req_in;
   logic [15:0] rd_data_out, ext_addr_out, ext_addr_oe_n_out, ext_addr_in;
   logic [15:0] ext_data_out, ext_data_in, mem_drv, pin_ext, prev_addr;
   logic        prog_sel_n, data_sel_n, read_n, write_n, ctl_oe_n;
   logic        data_oe_n, slow, prev_busy, saw_full;
   logic [1:0]  e_sel, e_dir, e_dout, e_din;
   logic [7:0]  a_sel, a_dir, a_dout, a_din;
   logic [9:0]  io_sel, io_dir, io_dout;
   logic [15:0] pool [4];      // Addresses reused so reads hit writes
   logic [15:0] bmem [int];    // Bench copy of memory contents
   emb_req_type qexp [$];      // Taken requests not yet on the bus
   logic [15:0] rexp [$];      // Read words awaited
   int          errors, n_checks;

   assign io_sel  = {a_sel, e_sel};
   assign io_dir  = {a_dir, e_dir};
   assign io_dout = {a_dout, e_dout};
   // Pin levels: whoever enables a line decides it
   assign ext_data_in = data_oe_n ? mem_drv : ext_data_out;
   assign ext_addr_in = (ext_addr_oe_n_out & pin_ext)
                      | (~ext_addr_oe_n_out & ext_addr_out);

   initial clk_in = 1'b0;
   always #2 clk_in = ~clk_in;

   emb_port #(.STROBE_CYC(5), .FIFO_DEPTH(4)) DUT (
      .clk_in(clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
      .req_in(req_in), .req_ready_out(req_ready_out),
      .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
      .program_space_select_n_out(prog_sel_n),
      .data_space_select_n_out(data_sel_n),
      .read_strobe_n_out(read_n), .write_strobe_n_out(write_n),
      .ctl_oe_n_out(ctl_oe_n), .ext_addr_out(ext_addr_out),
      .ext_addr_oe_n_out(ext_addr_oe_n_out), .ext_addr_in(ext_addr_in),
      .ext_data_out(ext_data_out), .ext_data_oe_n_out(data_oe_n),
      .ext_data_in(ext_data_in), .port_e_alt_io_sel_in(e_sel),
      .port_e_alt_io_dir_in(e_dir), .port_e_alt_io_dout_in(e_dout),
      .port_e_alt_io_din_out(e_din), .port_a_alt_io_sel_in(a_sel),
      .port_a_alt_io_dir_in(a_dir), .port_a_alt_io_dout_in(a_dout),
      .port_a_alt_io_din_out(a_din));

   emb_mem_model mem_model (
      .clk_in(clk_in), .prog_sel_n_in(prog_sel_n), .data_sel_n_in(data_sel_n),
      .read_n_in(read_n), .write_n_in(write_n), .addr_in(ext_addr_in),
      .data_in(ext_data_in), .slow_in(slow), .data_out(mem_drv));

   // ==========================================================
   // Comparison, verdict and test end
   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Bench model of a word: last write, else the memory's fill pattern
   function automatic logic [15:0] mem_word(input emb_req_type e);
      int k;
      k = int'({e.prog, e.addr});
      if (bmem.exists(k))
         return bmem[k];
      return e.addr ^ (e.prog ? 16'h5555 : 16'haaaa);
   endfunction

   // ==========================================================
   // Bus monitor, sampled at the falling edge where pins are settled
   always @(negedge clk_in) begin : monitor
      emb_req_type e;
      logic [15:0] m;
      m = ~{io_sel, 6'h00};
      if (!rst_in && !(read_n && write_n)) begin
         check("strobe overlap", read_n | write_n, 1'b1);
         check("data enable", data_oe_n, read_n ? 1'b0 : 1'b1);
         if (!prev_busy) begin
            // New cycle: pair it with the oldest taken request
            e = qexp.size() ? qexp.pop_front() : emb_req_type'('1);
            check("address", ext_addr_out & m, e.addr & m);
            check("program select", prog_sel_n, !e.prog);
            check("data select", data_sel_n, e.prog);
            check("cycle kind", write_n, !e.wr);
            // Shared lines used as I/O carry the pin level to the memory
            e.addr = (e.addr & m) | (~m & {(io_dir & io_dout)
                     | (~io_dir & pin_ext[15:6]), 6'h00});
            if (e.wr) begin
               check("write data", ext_data_out, e.data);
               bmem[int'({e.prog, e.addr})] = e.data;
            end else begin
               rexp.push_back(mem_word(e));
            end
         end else begin
            check("address hold", ext_addr_out & m, prev_addr & m);
         end
         prev_addr = ext_addr_out;
      end else if (!rst_in && prog_sel_n && data_sel_n) begin
         check("data float", data_oe_n, 1'b1);
      end
      prev_busy = !rst_in && !(read_n && write_n);
      if (!rst_in && rd_valid_out) begin
         check("read data", rd_data_out,
               rexp.size() ? rexp.pop_front() : ~rd_data_out);
      end
   end

   // ==========================================================
   // Request stream tasks
   task automatic send(input emb_req_type r);
      int n;
      @(negedge clk_in);
      req_valid_in = 1'b1;
      req_in       = r;
      n            = 0;
      while (req_ready_out !== 1'b1 && n < 100) begin
         @(negedge clk_in);
         n++;
      end
      check("ready wait", 16'(n < 100), 16'h0001);
      if (n > 0)
         saw_full = 1'b1;
      @(posedge clk_in);
      qexp.push_back(r);
   endtask

   task automatic drain();
      int n;
      @(negedge clk_in);
      req_valid_in = 1'b0;
      n            = 0;
      while ((qexp.size() || rexp.size() || prev_busy) && n < 500) begin
         @(negedge clk_in);
         n++;
      end
      check("drained", 16'(n < 500), 16'h0001);
      repeat (4) @(negedge clk_in);
   endtask

   // Back-to-back requests: every kind and space first, then random
   task automatic burst(input int n, input string name);
      emb_req_type r;
      for (int i = 0; i < n; i++) begin
         r.wr   = (i < 4) ? i[0] : 1'($urandom);
         r.prog = (i < 4) ? i[1] : 1'($urandom);
         r.addr = pool[$urandom % 4];
         r.data = 16'($urandom);
         send(r);
      end
      drain();
      $display("test %s done", name);
   endtask

   // Reset with the shared lines asked to be I/O; address must still win
   task automatic do_reset(input int cycles);
      @(negedge clk_in);
      rst_in = 1'b1;
      {a_sel, e_sel} = 10'h3ff;
      repeat (cycles) @(negedge clk_in);
      check("reset strobes", {read_n, write_n}, 2'b11);
      check("reset selects", {prog_sel_n, data_sel_n}, 2'b11);
      check("reset enables", {ctl_oe_n, data_oe_n}, 2'b11);
      check("reset address float", ext_addr_oe_n_out, 16'hffff);
      check("reset ready", {req_ready_out, rd_valid_out}, 2'b00);
      rst_in = 1'b0;
      @(negedge clk_in);
      check("control driven", ctl_oe_n, 1'b0);
      check("address function", ext_addr_oe_n_out, 16'h0000);
      check("ready after reset", req_ready_out, 1'b1);
      {a_sel, e_sel} = 10'h000;
      $display("test reset done");
   endtask

   // Shared lines as I/O: per-line direction, output value and input level
   task automatic gpio_round();
      @(negedge clk_in);
      {a_sel, e_sel}   = 10'($urandom);
      {a_dir, e_dir}   = 10'($urandom);
      {a_dout, e_dout} = 10'($urandom);
      pin_ext          = 16'($urandom);
      repeat (6) @(negedge clk_in);
      check("shared enables", ext_addr_oe_n_out, {io_sel & ~io_dir, 6'h00});
      check("shared out", ext_addr_out[15:6] & io_sel & io_dir,
            io_dout & io_sel & io_dir);
      check("shared in", {a_din, e_din} & io_sel,
            ((io_dir & io_dout) | (~io_dir & pin_ext[15:6])) & io_sel);
      $display("test shared io done");
   endtask

   // ==========================================================
   // Main sequence
   initial begin : main
      rst_in = 1'b1;
      req_valid_in = 1'b0;
      req_in = '0;
      slow = 1'b0;
      {a_sel, e_sel, a_dir, e_dir, a_dout, e_dout} = 30'h0;
      pin_ext = 16'h0000;
      prev_addr = 16'h0000;
      prev_busy = 1'b0;
      saw_full = 1'b0;
      errors = 0;
      n_checks = 0;
      void'($urandom(51203));
      pool[0] = 16'h0000;
      pool[1] = 16'hffff;
      pool[2] = 16'($urandom);
      pool[3] = 16'($urandom);
      do_reset(12);
      burst(28, "traffic");
      check("buffer fills", saw_full, 1'b1);
      slow = 1'b1;
      burst(12, "slow memory");
      slow = 1'b0;
      repeat (3) gpio_round();
      burst(6, "shared io with traffic");
      do_reset(3);
      burst(4, "after second reset");
      finish_test();
   end

   // Watchdog against a hung handshake
   initial begin : watchdog
      repeat (20000) @(posedge clk_in);
      errors++;
      finish_test();
   end
endmodule // tb_external_memory_bus_port

`default_nettype wire
